/* design/klfs_top.sv */
// Key lock and fault supervisor top with APB registers.
`timescale 1ns/100ps
// How it works
// - Key restrictions apply only while the protect switch is on.
// - Mode change keys are ignored at every protect level.
// - Display switching works at levels 1 to 4 and is blocked at 5 to 7, level 1 being default.
// - Reset key works at levels 1, 3, 6 and up/down keys at levels 1, 2, 6, 7.
// - Underflow is flagged below -99999 on six digits or -999 on four digits.
// - Overflow above 999999 or 9999 is flagged only in the listed modes or dual or tachometer use.
// - Under or overflow keeps outputs and flashes the main display at one second, cleared by reset.
// - In tachometer use overflow is not cleared by reset.
// - Processor fault shows its code, blanks the sub display, forces outputs off, cleared by reset key.
// - Working memory fault shows its code, blank sub display, outputs off, cleared only by power on.
// - Non-volatile memory fault forces outputs off and reset key restores factory settings.
// - Each alarm threshold is 0 to 9999 thousands and zero disables it.
// - Alarm rises when either output count exceeds its threshold with outputs unchanged.
// - While the alarm shows, the display alternates normal content and the alarm code.
// - Reset key does not clear the output counts, which keep counting.
// - After reset key the alarm code is no longer shown.
module klfs_top (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        protect_sw,
    input  wire logic        key_mode,
    input  wire logic        key_disp,
    input  wire logic        key_reset,
    input  wire logic        key_updn,
    input  wire logic        reset_in,
    input  wire logic        cpu_fault,
    input  wire logic        ram_fault,
    input  wire logic        nvm_fault,
    input  wire logic        out1_on,
    input  wire logic        out2_on,
    input  wire logic        pv_neg,
    input  wire logic [23:0] pv_mag,
    output logic             mode_req,
    output logic             disp_req,
    output logic             reset_req,
    output logic             updn_req,
    output logic             factory_req,
    output logic             outputs_off,
    output logic             outputs_hold,
    output logic             main_blank,
    output logic             sub_blank,
    output logic [3:0]       fault_code,
    output logic             irq
);
    import klfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and state.
    localparam int NS = 12;
    typedef struct packed {
        logic [NS-1:0] s1;
        logic [NS-1:0] s2;
        logic [NS-1:0] s3;
        logic [2:0]    level;
        logic          six_digit;
        logic          tacho;
        logic          ovf_mode;
        logic [NST-1:0] status;
        logic [NST-1:0] mask;
        logic [13:0]   thr1;
        logic [13:0]   thr2;
        logic [9:0]    sub1;
        logic [9:0]    sub2;
        logic [13:0]   cnt1;
        logic [13:0]   cnt2;
        logic          under;
        logic          over;
        logic          cpu;
        logic          ram;
        logic          nvm;
        logic          alarm_show;
        logic [31:0]   flash_cnt;
        logic          phase;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic          mode_req;
        logic          disp_req;
        logic          reset_req;
        logic          updn_req;
        logic          factory_req;
        logic          outputs_off;
        logic          outputs_hold;
        logic          main_blank;
        logic          sub_blank;
        logic [3:0]    fault_code;
        logic          irq;
    } klfs_state_s;

    klfs_state_s st_r;
    klfs_state_s st_nxt;
    logic allow_mode;
    logic allow_disp;
    logic allow_reset;
    logic allow_updn;

    klfs_gate u_gate (
        .protect_on  (st_r.s2[0]),
        .level       (st_r.level),
        .allow_mode  (allow_mode),
        .allow_disp  (allow_disp),
        .allow_reset (allow_reset),
        .allow_updn  (allow_updn)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic [NS-1:0] rise;
        logic          rkey;
        logic          clr;
        logic          wr;
        logic          rd;
        logic [24:0]   ulim;
        logic [24:0]   olim;
        logic          ev_alarm;
        logic          a1;
        logic          a2;
        logic [NST-1:0] ev;
        logic          any_pv;
        st_nxt = st_r;
        st_nxt.s1 = {key_mode, pv_neg, out2_on, out1_on, nvm_fault, ram_fault, cpu_fault,
                     reset_in, key_updn, key_reset, key_disp, protect_sw};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        rise = st_r.s2 & ~st_r.s3;
        rkey = rise[2] && allow_reset;
        clr  = rkey || rise[4];
        wr   = psel && penable && pwrite;
        rd   = psel && !penable && !pwrite;
        ulim = st_r.six_digit ? UNDER6 : UNDER4;
        olim = st_r.six_digit ? OVER6 : OVER4;
        // Output ON counts in thousands; never cleared by the reset key.
        st_nxt.sub1 = (rise[8]) ? ((st_r.sub1 == KILO) ? 10'h000 : st_r.sub1 + 10'h001) : st_r.sub1;
        st_nxt.sub2 = (rise[9]) ? ((st_r.sub2 == KILO) ? 10'h000 : st_r.sub2 + 10'h001) : st_r.sub2;
        if (rise[8] && st_r.sub1 == KILO && st_r.cnt1 != 14'h3fff) begin
            st_nxt.cnt1 = st_r.cnt1 + 14'h0001;
        end
        if (rise[9] && st_r.sub2 == KILO && st_r.cnt2 != 14'h3fff) begin
            st_nxt.cnt2 = st_r.cnt2 + 14'h0001;
        end
        a1 = st_r.thr1 != 14'h0000 && st_r.cnt1 > st_r.thr1;
        a2 = st_r.thr2 != 14'h0000 && st_r.cnt2 > st_r.thr2;
        ev_alarm = (a1 || a2) && !st_r.status[ST_ALARM];
        any_pv = st_r.under || st_r.over;
        // Present value limits.
        if (st_r.s2[10] && {1'b0, pv_mag} > ulim) begin
            st_nxt.under = 1'b1;
        end else if (clr && st_r.under) begin
            st_nxt.under = 1'b0;
        end
        if (!st_r.s2[10] && {1'b0, pv_mag} > olim && (st_r.ovf_mode || st_r.tacho)) begin
            st_nxt.over = 1'b1;
        end else if (clr && st_r.over && !st_r.tacho) begin
            st_nxt.over = 1'b0;
        end
        if (st_r.s2[5]) begin
            st_nxt.cpu = 1'b1;
        end else if (rkey) begin
            st_nxt.cpu = 1'b0;
        end
        if (st_r.s2[6]) begin
            st_nxt.ram = 1'b1;
        end
        if (st_r.s2[7]) begin
            st_nxt.nvm = 1'b1;
        end else if (rkey) begin
            st_nxt.nvm = 1'b0;
        end
        if (a1 || a2) begin
            if (rkey) begin
                st_nxt.alarm_show = 1'b0;
            end else if (ev_alarm) begin
                st_nxt.alarm_show = 1'b1;
            end
        end else begin
            st_nxt.alarm_show = 1'b0;
        end
        // One second flash and alternate phase.
        if (st_r.flash_cnt >= FLASH_HALF_DEF - 32'h1) begin
            st_nxt.flash_cnt = 32'h0;
            st_nxt.phase = !st_r.phase;
        end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 32'h1;
        end
        ev = {ev_alarm, st_r.nvm ^ st_nxt.nvm && st_nxt.nvm, !st_r.ram && st_nxt.ram,
              !st_r.cpu && st_nxt.cpu, !st_r.over && st_nxt.over, !st_r.under && st_nxt.under};
        st_nxt.status = (st_r.status & ~((psel && penable && pwrite && paddr == ADDR_STATUS)
                        ? pwdata[NST-1:0] : '0)) | ev;
        // Register writes.
        if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    st_nxt.six_digit = pwdata[0];
                    st_nxt.tacho     = pwdata[1];
                    st_nxt.ovf_mode  = pwdata[2];
                end
                ADDR_LEVEL: begin
                    if (pwdata[2:0] != 3'h0) begin
                        st_nxt.level = pwdata[2:0];
                    end
                end
                ADDR_MASK: st_nxt.mask = pwdata[NST-1:0];
                ADDR_THR1: st_nxt.thr1 = (pwdata > {18'h0, THR_MAX}) ? THR_MAX : pwdata[13:0];
                ADDR_THR2: st_nxt.thr2 = (pwdata > {18'h0, THR_MAX}) ? THR_MAX : pwdata[13:0];
                default: begin
                end
            endcase
        end
        if (st_r.nvm && rkey) begin
            st_nxt.level = LEVEL_RST;
            st_nxt.thr1  = 14'h0000;
            st_nxt.thr2  = 14'h0000;
        end
        // APB answer, no wait cycle.
        st_nxt.pready = psel && !penable;
        st_nxt.pslverr = 1'b0;
        if (rd) begin
            case (paddr)
                ADDR_CTRL:   st_nxt.prdata = {29'h0, st_r.ovf_mode, st_r.tacho, st_r.six_digit};
                ADDR_LEVEL:  st_nxt.prdata = {29'h0, st_r.level};
                ADDR_STATUS: st_nxt.prdata = {26'h0, st_r.status};
                ADDR_MASK:   st_nxt.prdata = {26'h0, st_r.mask};
                ADDR_THR1:   st_nxt.prdata = {18'h0, st_r.thr1};
                ADDR_THR2:   st_nxt.prdata = {18'h0, st_r.thr2};
                ADDR_CNT1:   st_nxt.prdata = {18'h0, st_r.cnt1};
                ADDR_CNT2:   st_nxt.prdata = {18'h0, st_r.cnt2};
                ADDR_FLT:    st_nxt.prdata = {26'h0, st_r.alarm_show, st_r.nvm, st_r.ram,
                                              st_r.cpu, st_r.over, st_r.under};
                default: begin
                    st_nxt.prdata  = 32'h0;
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end else if (!psel) begin
            st_nxt.prdata = 32'h0;
        end
        if (psel && !penable && pwrite) begin
            st_nxt.pslverr = !(paddr inside {ADDR_CTRL, ADDR_LEVEL, ADDR_STATUS, ADDR_MASK,
                                              ADDR_THR1, ADDR_THR2, ADDR_CNT1, ADDR_CNT2, ADDR_FLT});
        end
        // Key requests.
        st_nxt.mode_req  = rise[11] && allow_mode;
        st_nxt.disp_req  = rise[1] && allow_disp;
        st_nxt.reset_req = rkey || rise[4];
        st_nxt.updn_req  = rise[3] && allow_updn;
        st_nxt.factory_req = st_r.nvm && rkey;
        // Display and outputs.
        st_nxt.outputs_off  = st_r.cpu || st_r.ram || st_r.nvm;
        st_nxt.outputs_hold = any_pv || st_r.status[ST_ALARM];
        st_nxt.sub_blank    = st_r.cpu || st_r.ram;
        st_nxt.main_blank   = !(st_r.cpu || st_r.ram || st_r.nvm) && any_pv && st_r.phase;
        if (st_r.ram) begin
            st_nxt.fault_code = MEMORY_FAULT_CODE;
        end else if (st_r.cpu) begin
            st_nxt.fault_code = CODE_CPU;
        end else if (st_r.nvm) begin
            st_nxt.fault_code = CODE_NVM;
        end else if (st_r.alarm_show && st_r.phase) begin
            st_nxt.fault_code = OUTPUT_COUNT_ALARM_CODE;
        end else begin
            st_nxt.fault_code = CODE_NONE;
        end
        st_nxt.irq = |(st_r.status & st_r.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r       <= '0;
            st_r.level <= LEVEL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign mode_req    = st_r.mode_req;
    assign disp_req    = st_r.disp_req;
    assign reset_req   = st_r.reset_req;
    assign updn_req    = st_r.updn_req;
    assign factory_req = st_r.factory_req;
    assign outputs_off = st_r.outputs_off;
    assign outputs_hold = st_r.outputs_hold;
    assign main_blank  = st_r.main_blank;
    assign sub_blank   = st_r.sub_blank;
    assign fault_code  = st_r.fault_code;
    assign irq         = st_r.irq;
endmodule

/* design/klfs_pkg.sv */
// Package of constants and types for the key lock and fault supervisor.
package klfs_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned FLASH_PERIOD_MS = 1000;
    localparam int unsigned FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_PERIOD_MS / 2;
    localparam logic [31:0] FLASH_HALF_DEF  = 32'(FLASH_HALF_CYC);
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_LEVEL      = 12'h004;
    localparam logic [11:0] ADDR_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_MASK       = 12'h00c;
    localparam logic [11:0] ADDR_THR1       = 12'h010;
    localparam logic [11:0] ADDR_THR2       = 12'h014;
    localparam logic [11:0] ADDR_CNT1       = 12'h018;
    localparam logic [11:0] ADDR_CNT2       = 12'h01c;
    localparam logic [11:0] ADDR_FLT        = 12'h020;
    localparam logic [2:0]  LEVEL_RST       = 3'h1;
    localparam logic [13:0] THR_MAX         = 14'h270f;
    localparam logic [9:0]  KILO            = 10'h3e7;
    localparam int          ST_UNDER        = 0;
    localparam int          ST_OVER         = 1;
    localparam int          ST_CPU          = 2;
    localparam int          ST_RAM          = 3;
    localparam int          ST_NVM          = 4;
    localparam int          ST_ALARM        = 5;
    localparam int          NST             = 6;
    localparam logic [3:0]  CODE_NONE       = 4'h0;
    localparam logic [3:0]  CODE_CPU        = 4'h1;
    localparam logic [3:0]  MEMORY_FAULT_CODE = 4'h2;
    localparam logic [3:0]  OUTPUT_COUNT_ALARM_CODE = 4'h3;
    localparam logic [3:0]  CODE_NVM        = 4'h4;
    localparam logic [24:0] UNDER6          = 25'h001869f;
    localparam logic [24:0] UNDER4          = 25'h00003e7;
    localparam logic [24:0] OVER6           = 25'h00f423f;
    localparam logic [24:0] OVER4           = 25'h000270f;
endpackage

/* design/klfs_gate.sv */
// Key gating by key protection level.
`timescale 1ns/100ps
module klfs_gate (
    input  wire logic       protect_on,
    input  wire logic [2:0] level,
    output logic            allow_mode,
    output logic            allow_disp,
    output logic            allow_reset,
    output logic            allow_updn
);
    import klfs_pkg::*;
    always_comb begin
        allow_mode  = !protect_on;
        allow_disp  = !protect_on || (level >= 3'h1 && level <= 3'h4);
        allow_reset = !protect_on || level == 3'h1 || level == 3'h3 || level == 3'h6;
        allow_updn  = !protect_on || level == 3'h1 || level == 3'h2 || level == 3'h6 || level == 3'h7;
    end
endmodule

/* testbench/klfs_properties.sv */
// Port checks for the key lock and fault supervisor.
`timescale 1ns/100ps
module klfs_properties
    import klfs_pkg::*;
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        protect_sw,
    input wire logic        key_disp,
    input wire logic        key_updn,
    input wire logic        mode_req,
    input wire logic        disp_req,
    input wire logic        reset_req,
    input wire logic        updn_req,
    input wire logic        factory_req,
    input wire logic        outputs_off,
    input wire logic        sub_blank,
    input wire logic [3:0]  fault_code,
    input wire logic        irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    setup_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not in one cycle");
    bad_addr_a: assert property (pready && paddr > ADDR_FLT |-> pslverr && prdata == 32'h0) else $error("bad address");
    mode_lock_a: assert property (mode_req |-> !$past(protect_sw, 3)) else $error("mode key passed lock");
    disp_cause_a: assert property (disp_req |-> $past(key_disp, 3)) else $error("display request uncaused");
    updn_cause_a: assert property (updn_req |-> $past(key_updn, 3)) else $error("up down request uncaused");
    reset_pulse_a: assert property (reset_req |=> !reset_req ##1 !reset_req) else $error("reset request too long");
    cpu_off_a: assert property (fault_code == CODE_CPU |-> outputs_off && sub_blank)
        else $error("cpu fault output");
    ram_off_a: assert property (fault_code == MEMORY_FAULT_CODE |-> outputs_off && sub_blank)
        else $error("ram fault");
    nvm_off_a: assert property (fault_code == CODE_NVM |-> outputs_off) else $error("nvm fault outputs on");
    cover property (mode_req);
    cover property (factory_req);
    cover property (irq);
    cover property (fault_code == MEMORY_FAULT_CODE);
endmodule
bind klfs_top klfs_properties u_props (.*);

/* testbench/klfs_panel.sv */
// Front panel model: presses keys and records the accepted key actions.
`timescale 1ns/100ps
module klfs_panel (
    input  wire logic       clock,
    input  wire logic [4:0] press,
    input  wire logic       mode_req,
    input  wire logic       disp_req,
    input  wire logic       reset_req,
    input  wire logic       updn_req,
    input  wire logic       factory_req,
    output logic            key_mode,
    output logic            key_disp,
    output logic            key_reset,
    output logic            key_updn,
    output logic            reset_in,
    output logic [4:0]      seen
);
    logic [4:0] pins = 5'h00;
    logic [3:0] hold = 4'h0;
    initial seen = 5'h00;
    // A released key opens and reads low.
    assign {reset_in, key_updn, key_reset, key_disp, key_mode} = pins;
    always @(posedge clock) begin
        if (press != 5'h00) begin
            pins <= press;
            hold <= 4'h8;
            seen <= 5'h00;
        end else begin
            if (hold == 4'h1) pins <= 5'h00;
            if (hold != 4'h0) hold <= hold - 4'h1;
            seen <= seen | {factory_req, updn_req, reset_req, disp_req, mode_req};
        end
    end
endmodule

/* testbench/test_key_lock_and_fault_supervisor.sv */
// Self-checking testbench of the key lock and fault supervisor.
`timescale 1ns/100ps
module test_key_lock_and_fault_supervisor;
    import klfs_pkg::*;
    logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, protect_sw = 0, pv_neg = 0;
    logic cpu_fault = 0, ram_fault = 0, nvm_fault = 0, out1_on = 0, out2_on = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [23:0] pv_mag = 0;
    logic [4:0] press = 0, seen;
    logic pready, pslverr, key_mode, key_disp, key_reset, key_updn, reset_in;
    logic mode_req, disp_req, reset_req, updn_req, factory_req, outputs_off, outputs_hold;
    logic main_blank, sub_blank, irq;
    logic [3:0] fault_code;
    int n_errors = 0, num_checks = 0, cyc = 0;
    klfs_top DUT (.*);
    klfs_panel panel (.*);
    initial forever #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task results;
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            results;
        end
    end
    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock); penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task key(input logic [4:0] k, input logic [4:0] e, input string nm);
        @(posedge clock) press <= k;
        @(posedge clock) press <= 0;
        repeat (20) @(posedge clock);
        check(nm, seen, e);
    endtask
    task ops(input int n, input logic [1:0] w);
        repeat (n) begin
            @(posedge clock); out1_on <= w[0]; out2_on <= w[1];
            repeat (2) @(posedge clock); out1_on <= 0; out2_on <= 0;
            repeat (2) @(posedge clock);
        end
    endtask
    task settle;
        repeat (6) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        apb(0, ADDR_LEVEL, 0); check("level reset", rd, 1);
        apb(1, ADDR_LEVEL, 0); apb(0, ADDR_LEVEL, 0); check("level zero", rd, 1);
        apb(0, 12'h040, 0); check("unmapped err", er, 1); check("unmapped data", rd, 0);
        apb(1, ADDR_THR1, 10000); apb(0, ADDR_THR1, 0); check("thr clamp", rd, THR_MAX);
    endtask
    task t_levels;
        protect_sw <= 1;
        for (int lv = 1; lv < 8; lv++) begin
            apb(1, ADDR_LEVEL, lv); settle;
            key(5'h01, 5'h00, "mode");
            key(5'h02, (lv < 5) ? 5'h02 : 5'h00, "disp");
            key(5'h04, (lv == 1 || lv == 3 || lv == 6) ? 5'h04 : 5'h00, "reset");
            key(5'h08, (lv inside {1, 2, 6, 7}) ? 5'h08 : 5'h00, "updn");
        end
        protect_sw <= 0; settle;
        key(5'h01, 5'h01, "mode free");
        key(5'h02, 5'h02, "disp free");
        apb(1, ADDR_LEVEL, 1);
    endtask
    task t_count;
        apb(1, ADDR_THR1, 0); apb(1, ADDR_THR2, 0); apb(1, ADDR_MASK, 32'h20);
        ops(2001, 2'b11); apb(0, ADDR_STATUS, 0); check("zero thr", rd[5], 0);
        apb(0, ADDR_CNT2, 0); check("cnt2", rd, 2);
        apb(1, ADDR_THR1, 1); ops(1, 2'b01); apb(0, ADDR_STATUS, 0); check("alarm", rd[5], 1);
        settle; check("irq", irq, 1); check("outs kept", outputs_off, 0);
        apb(1, ADDR_MASK, 0); settle; check("irq masked", irq, 0);
        apb(1, ADDR_MASK, 32'h20); settle; check("irq unmasked", irq, 1);
        check("normal half", fault_code, CODE_NONE);
        apb(0, ADDR_FLT, 0); check("alarm shown", rd[5], 1);
        key(5'h04, 5'h04, "reset alarm"); check("code gone", fault_code !== OUTPUT_COUNT_ALARM_CODE, 1);
        apb(0, ADDR_FLT, 0); check("alarm hidden", rd[5], 0);
        apb(0, ADDR_CNT1, 0); check("cnt kept", rd, 2);
        apb(1, ADDR_THR1, 0); apb(1, ADDR_STATUS, 32'h20); settle; check("irq clear", irq, 0);
    endtask
    task t_fault;
        cpu_fault <= 1; settle; check("cpu code", fault_code, CODE_CPU);
        check("cpu off", {outputs_off, sub_blank}, 2'b11);
        cpu_fault <= 0; key(5'h04, 5'h04, "cpu rst"); check("cpu clr", fault_code, CODE_NONE);
        ram_fault <= 1; settle; ram_fault <= 0; key(5'h04, 5'h04, "ram rst");
        check("ram code", fault_code, MEMORY_FAULT_CODE);
        check("ram off", {outputs_off, sub_blank}, 2'b11);
        rstn <= 0; repeat (2) @(posedge clock); check("ram pwr", fault_code, CODE_NONE);
        rstn <= 1; apb(1, ADDR_LEVEL, 3); nvm_fault <= 1; settle; nvm_fault <= 0;
        check("nvm off", outputs_off, 1);
        key(5'h04, 5'h14, "nvm rst");
        apb(0, ADDR_LEVEL, 0); check("factory lvl", rd, 1);
    endtask
    task t_pv;
        apb(1, ADDR_CTRL, 1); pv_neg <= 1; pv_mag <= 100000; settle;
        apb(0, ADDR_STATUS, 0); check("under6", rd[0], 1); check("under hold", outputs_hold, 1);
        check("first half lit", main_blank, 0);
        pv_mag <= 0; pv_neg <= 0; key(5'h10, 5'h04, "rst in"); check("under clr", outputs_hold, 0);
        apb(1, ADDR_CTRL, 0); apb(1, ADDR_STATUS, 3); pv_neg <= 1; pv_mag <= 1000; settle;
        apb(0, ADDR_STATUS, 0); check("under4", rd[0], 1);
        pv_neg <= 0; pv_mag <= 0; key(5'h04, 5'h04, "under4 rst"); apb(1, ADDR_STATUS, 3);
        apb(1, ADDR_CTRL, 1); pv_mag <= 1000000; settle;
        apb(0, ADDR_STATUS, 0); check("no over", rd[1], 0);
        apb(1, ADDR_CTRL, 5); settle; apb(0, ADDR_STATUS, 0); check("over", rd[1], 1);
        pv_mag <= 0; key(5'h04, 5'h04, "over rst"); check("over clr", outputs_hold, 0);
        apb(1, ADDR_CTRL, 2); pv_mag <= 10000; settle; pv_mag <= 0;
        key(5'h04, 5'h04, "tacho rst"); check("tacho kept", outputs_hold, 1);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1;
        t_regs;
        t_levels;
        t_count;
        t_fault;
        t_pv;
        results;
    end
endmodule
